// file: logic/eec_pkg.sv
// What this block does
// - Twenty lines raise interrupt or event requests
// - Per-line rising, falling or both edges
// - Per-line mask blocks only that line
// - Detected interrupts latch into readable pending bits
// - Levels sampled each clock; pulses between two clock edges are missed
// - Sixteen pin lines, any of eighty pins
// - Monitor, alarm and USB wakeup drive upper lines
// - Enabled edge on any line wakes Stop
// - Monitor line fires on fall, rise or both
// - Monitor line silent until software enables it
// - Requests wake halted processor in Sleep
package eec_pkg;

  // Line counts and source positions
  localparam int NUM_LINES = 20;
  localparam int NUM_PIN_LINES = 16;
  localparam int NUM_GPIO = 80;
  localparam int SEL_W = 7;
  localparam int SEL_WORDS = 4;
  localparam int LINE_MONITOR = 16;
  localparam int LINE_RTC = 17;
  localparam int LINE_USB = 18;
  localparam int LINE_AUX = 19;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_INT_MASK = 8'h00;
  localparam logic [7:0] OFF_EVT_MASK = 8'h04;
  localparam logic [7:0] OFF_RISE = 8'h08;
  localparam logic [7:0] OFF_FALL = 8'h0c;
  localparam logic [7:0] OFF_PEND = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_LEVEL = 8'h18;
  localparam logic [7:0] OFF_SEL0 = 8'h1c;

  // Field positions
  localparam int CTRL_MON_EN_BIT = 0;
  localparam int SEL_FIELD_W = 8;

  // Reset values
  localparam logic [19:0] RST_MASK = 20'h00000;
  localparam logic [19:0] RST_TRIG = 20'h00000;
  localparam logic RST_MON_EN = 1'b0;

endpackage : eec_pkg

// file: logic/eec_line.sv
`timescale 1ns/1ps
module eec_line (
  input wire logic clk, // Block clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic level_i, // Source level
  input wire logic det_en_i, // Detection allowed
  input wire logic rise_en_i, // Trigger on rising edge
  input wire logic fall_en_i, // Trigger on falling edge
  input wire logic int_en_i, // Interrupt mask bit, 1 forwards
  input wire logic evt_en_i, // Event mask bit, 1 forwards
  input wire logic clr_i, // Pending clear strobe
  output logic pend_o, // Pending status
  output logic evt_o, // One-cycle event pulse
  output logic wake_o, // Unclocked wake request
  output logic level_o // Last captured level
);

  logic prev_q;
  logic prime_q;
  logic pend_q;
  logic evt_q;
  wire rise_seen;
  wire fall_seen;
  wire hit;

  // Edge compare against the last captured level
  assign rise_seen = level_i & ~prev_q;
  assign fall_seen = ~level_i & prev_q;
  // Priming avoids a false edge from the reset value of prev_q
  assign hit = prime_q & det_en_i & ((rise_en_i & rise_seen) | (fall_en_i & fall_seen));
  // No clock needed here, so this still works with clocks stopped
  assign wake_o = hit & (int_en_i | evt_en_i);
  assign pend_o = pend_q;
  assign evt_o = evt_q;
  assign level_o = prev_q;

  // Level capture
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prev_q <= 1'b0;
      prime_q <= 1'b0;
    end
    else
    begin
      prev_q <= level_i;
      prime_q <= 1'b1;
    end
  end

  // Pending bit: a new edge wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pend_q <= 1'b0;
    else
      pend_q <= (hit & int_en_i) | (pend_q & ~clr_i);
  end

  // Event pulse, never latched
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      evt_q <= 1'b0;
    else
      evt_q <= hit & evt_en_i;
  end

endmodule : eec_line

// file: logic/eec_top.sv
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module eec_top (
  input wire logic clk, // Block clock, 25 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, 1 write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [79:0] gpio_i, // General-purpose pin levels
  input wire logic monitor_i, // Supply monitor, high below threshold
  input wire logic rtc_alarm_i, // Real-time clock alarm
  input wire logic usb_wake_i, // USB wakeup
  input wire logic aux_i, // Spare source for the last line
  output logic monitor_en_o, // Enable to the supply monitor
  output logic [19:0] irq_o, // Interrupt requests per line
  output logic event_o, // One-cycle event pulse
  output logic cpu_wake_o, // Sleep-mode wake request
  output logic stop_wake_o // Stop-mode wake, unclocked
);

  localparam int N = eec_pkg::NUM_LINES;
  localparam int NP = eec_pkg::NUM_PIN_LINES;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus phase decode

  wire acc;
  wire wr;
  wire rd_setup;

  // Writes land at the access edge, reads are fetched in setup
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire hit_int;
  wire hit_evt;
  wire hit_rise;
  wire hit_fall;
  wire hit_pend;
  wire hit_ctrl;
  wire hit_level;
  wire [3:0] hit_sel;
  wire hit_any;

  assign hit_int = paddr == eec_pkg::OFF_INT_MASK;
  assign hit_evt = paddr == eec_pkg::OFF_EVT_MASK;
  assign hit_rise = paddr == eec_pkg::OFF_RISE;
  assign hit_fall = paddr == eec_pkg::OFF_FALL;
  assign hit_pend = paddr == eec_pkg::OFF_PEND;
  assign hit_ctrl = paddr == eec_pkg::OFF_CTRL;
  assign hit_level = paddr == eec_pkg::OFF_LEVEL;
  assign hit_sel[0] = paddr == eec_pkg::OFF_SEL0;
  assign hit_sel[1] = paddr == eec_pkg::OFF_SEL0 + 8'h04;
  assign hit_sel[2] = paddr == eec_pkg::OFF_SEL0 + 8'h08;
  assign hit_sel[3] = paddr == eec_pkg::OFF_SEL0 + 8'h0c;
  assign hit_any = hit_int | hit_evt | hit_rise | hit_fall | hit_pend
                 | hit_ctrl | hit_level | (|hit_sel);

  // Zero wait states keep the master simple
  assign pready = 1'b1;
  // Unmapped offsets answer with an error, writes are dropped
  assign pslverr = acc & ~hit_any;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [19:0] int_mask_q;
  logic [19:0] evt_mask_q;
  logic [19:0] rise_q;
  logic [19:0] fall_q;
  logic mon_en_q;
  logic [31:0] rdata_q;
  logic [6:0] sel_q [NP];

  // Interrupt mask, 1 lets the line through
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      int_mask_q <= eec_pkg::RST_MASK;
    else if (wr && hit_int)
      int_mask_q <= pwdata[N-1:0];
  end

  // Event mask, 1 lets the line through
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      evt_mask_q <= eec_pkg::RST_MASK;
    else if (wr && hit_evt)
      evt_mask_q <= pwdata[N-1:0];
  end

  // Rising-edge trigger selection
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rise_q <= eec_pkg::RST_TRIG;
    else if (wr && hit_rise)
      rise_q <= pwdata[N-1:0];
  end

  // Falling-edge trigger selection
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fall_q <= eec_pkg::RST_TRIG;
    else if (wr && hit_fall)
      fall_q <= pwdata[N-1:0];
  end

  // Supply monitor enable, off until software sets it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mon_en_q <= eec_pkg::RST_MON_EN;
    else if (wr && hit_ctrl)
      mon_en_q <= pwdata[eec_pkg::CTRL_MON_EN_BIT];
  end

  assign monitor_en_o = mon_en_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin source selection

  wire [NP-1:0] pin_lvl;
  wire [7:0] sel_byte [NP];
  wire [31:0] sel_word [eec_pkg::SEL_WORDS];

  // Each pin line picks one of the pins; out-of-range codes read low
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_sel
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          sel_q[gi] <= 7'(gi);
        else if (wr && hit_sel[gi / 4])
          sel_q[gi] <= pwdata[(gi % 4) * eec_pkg::SEL_FIELD_W +: eec_pkg::SEL_W];
      end
      assign pin_lvl[gi] = (sel_q[gi] < 7'(eec_pkg::NUM_GPIO)) ? gpio_i[sel_q[gi]] : 1'b0;
      assign sel_byte[gi] = {1'b0, sel_q[gi]};
    end
  endgenerate

  // Four selection fields packed into each word
  generate
    for (gi = 0; gi < eec_pkg::SEL_WORDS; gi++)
    begin : g_word
      assign sel_word[gi] = {sel_byte[4*gi+3], sel_byte[4*gi+2],
                             sel_byte[4*gi+1], sel_byte[4*gi]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Line source assembly

  wire [N-1:0] src_lvl;
  wire [N-1:0] det_en;

  assign src_lvl[NP-1:0] = pin_lvl;
  assign src_lvl[eec_pkg::LINE_MONITOR] = monitor_i;
  assign src_lvl[eec_pkg::LINE_RTC] = rtc_alarm_i;
  assign src_lvl[eec_pkg::LINE_USB] = usb_wake_i;
  assign src_lvl[eec_pkg::LINE_AUX] = aux_i;

  // Monitor line detects nothing while the monitor is off
  // Built bit by bit, so no cast or shift can spread the enable to other lines
  assign det_en = {{(N - eec_pkg::LINE_MONITOR - 1){1'b1}}, mon_en_q,
                   {eec_pkg::LINE_MONITOR{1'b1}}};

  ////////////////////////////////////////////////////////////////////////////////
  // Edge lines

  wire [N-1:0] pend;
  wire [N-1:0] evt;
  wire [N-1:0] wake;
  wire [N-1:0] lvl;
  wire [N-1:0] clr;

  // Write one to a pending bit to clear it
  assign clr = (wr && hit_pend) ? pwdata[N-1:0] : '0;

  generate
    for (gi = 0; gi < N; gi++)
    begin : g_line
      eec_line u_line (
        .clk(clk),
        .rst_n(rst_n),
        .level_i(src_lvl[gi]),
        .det_en_i(det_en[gi]),
        .rise_en_i(rise_q[gi]),
        .fall_en_i(fall_q[gi]),
        .int_en_i(int_mask_q[gi]),
        .evt_en_i(evt_mask_q[gi]),
        .clr_i(clr[gi]),
        .pend_o(pend[gi]),
        .evt_o(evt[gi]),
        .wake_o(wake[gi]),
        .level_o(lvl[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Requests out

  // Pending bits are already gated by the mask when they set
  assign irq_o = pend;
  assign event_o = |evt;
  // Processor halted only; peripherals keep feeding requests
  assign cpu_wake_o = (|pend) | (|evt);
  // Combinational path so Stop can be left without a clock
  assign stop_wake_o = |wake;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  wire [31:0] rd_mux;
  wire [31:0] pad_int;
  wire [31:0] pad_evt;
  wire [31:0] pad_rise;
  wire [31:0] pad_fall;
  wire [31:0] pad_pend;
  wire [31:0] pad_lvl;
  wire [31:0] pad_ctrl;

  assign pad_int = {12'h000, int_mask_q};
  assign pad_evt = {12'h000, evt_mask_q};
  assign pad_rise = {12'h000, rise_q};
  assign pad_fall = {12'h000, fall_q};
  assign pad_pend = {12'h000, pend};
  assign pad_lvl = {12'h000, lvl};
  assign pad_ctrl = {31'h00000000, mon_en_q};

  // Priority chain; unmapped reads return zero
  assign rd_mux = hit_int ? pad_int :
                  hit_evt ? pad_evt :
                  hit_rise ? pad_rise :
                  hit_fall ? pad_fall :
                  hit_pend ? pad_pend :
                  hit_ctrl ? pad_ctrl :
                  hit_level ? pad_lvl :
                  hit_sel[0] ? sel_word[0] :
                  hit_sel[1] ? sel_word[1] :
                  hit_sel[2] ? sel_word[2] :
                  hit_sel[3] ? sel_word[3] : 32'h00000000;

  // Captured in setup so prdata comes from a flop in access
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_q <= 32'h00000000;
    else if (rd_setup)
      rdata_q <= rd_mux;
  end

  assign prdata = rdata_q;

endmodule : eec_top

// file: verif/eec_checker.sv
`timescale 1ns/1ps
module eec_checker (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic monitor_en_o, // Monitor on
  input wire logic [19:0] irq_o, // Pending
  input wire logic cpu_wake_o, // Sleep wake
  input wire logic stop_wake_o // Edge seen
);
  logic acc;
  logic wr_pend;
  logic wr_ctrl;
  // Access-phase decodes
  assign acc = psel && penable;
  assign wr_pend = acc && pwrite && paddr == 8'h10;
  assign wr_ctrl = acc && pwrite && paddr == 8'h14;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A line that has just become pending
  sequence new_pend_s;
    (irq_o & ~$past(irq_o)) != 20'h0;
  endsequence
  ////////////////////
  bus_answer_a: assert property (acc && paddr[1:0] == 2'h0 |-> pready && pslverr == (paddr > 8'h28))
    else $error("bad bus answer");
  err_idle_a: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  pend_hold_a: assert property (!wr_pend |=> (irq_o & $past(irq_o)) == $past(irq_o))
    else $error("pending dropped alone");
  pend_clear_a: assert property (wr_pend && !stop_wake_o |=> (irq_o & $past(pwdata[19:0])) == 20'h0)
    else $error("pending not cleared");
  pend_cause_a: assert property (new_pend_s |-> $past(stop_wake_o))
    else $error("pending without edge");
  wake_level_a: assert property ((|irq_o) |-> cpu_wake_o)
    else $error("no sleep wake");
  mon_quiet_a: assert property (!monitor_en_o |=> !(irq_o[16] && !$past(irq_o[16])))
    else $error("monitor line fired while off");
  mon_hold_a: assert property (!wr_ctrl |=> $stable(monitor_en_o))
    else $error("monitor enable moved");
  mon_set_a: assert property (wr_ctrl |=> monitor_en_o == $past(pwdata[0]))
    else $error("monitor enable not written");
endmodule : eec_checker
bind eec_top eec_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .monitor_en_o(monitor_en_o), .irq_o(irq_o), .cpu_wake_o(cpu_wake_o),
  .stop_wake_o(stop_wake_o));

// file: verif/eec_src_model.sv
`timescale 1ns/1ps
module eec_src_model (
  input wire logic clk, // Clock
  input wire logic we, // Apply strobe
  input wire logic [6:0] idx, // Pin 0-79, then other sources
  input wire logic val, // New level
  output logic [83:0] src // Pins, monitor, alarm, usb, aux
);
  // Levels move only on the clock, as the design expects
  initial src = 84'h0;
  always @(posedge clk)
  begin
    if (we)
      src[idx] <= val;
  end
endmodule : eec_src_model

// file: verif/test_eec_top.sv
`timescale 1ns/1ps
module test_eec_top;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic we = 1'h0;
  logic val = 1'h0;
  logic [6:0] idx = 7'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, se, mon_en, evt, cpu_wake, stop_wake;
  logic [83:0] src;
  logic [19:0] irq;
  int err_total = 0;
  int samples_checked = 0;
  int ev_cnt = 0;
  eec_src_model u_src (.clk(clk), .we(we), .idx(idx), .val(val), .src(src));
  eec_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_i(src[79:0]), .monitor_i(src[80]), .rtc_alarm_i(src[81]), .usb_wake_i(src[82]),
    .aux_i(src[83]), .monitor_en_o(mon_en), .irq_o(irq), .event_o(evt),
    .cpu_wake_o(cpu_wake), .stop_wake_o(stop_wake));
  // Clock and event pulse counter
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (evt === 1'h1) ev_cnt++;
  ////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
    chk(se, ee);
  endtask : rdc
  // Change one source level, then let detection settle
  task automatic drv(input logic [6:0] i, input logic v);
    @(posedge clk);
    we <= 1'h1;
    idx <= i;
    val <= v;
    @(posedge clk);
    we <= 1'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : drv
  ////////////////////
  task automatic t_regs;
    rdc(8'h00, 32'h0, 1'h0);
    rdc(8'h10, 32'h0, 1'h0);
    rdc(8'h14, 32'h0, 1'h0);
    rdc(8'h1c, 32'h03020100, 1'h0);
    rdc(8'h40, 32'h0, 1'h1);
    $display("regs done");
  endtask : t_regs
  task automatic t_edges;
    apb(1'h1, 8'h00, 32'h20);
    for (int m = 1; m < 4; m++)
    begin
      apb(1'h1, 8'h08, {26'h0, m[0], 5'h0});
      apb(1'h1, 8'h0c, {26'h0, m[1], 5'h0});
      drv(7'h05, 1'h1);
      rdc(8'h10, {26'h0, m[0], 5'h0}, 1'h0);
      apb(1'h1, 8'h10, 32'h20);
      chk(irq, 32'h0);
      drv(7'h05, 1'h0);
      chk(irq, {26'h0, m[1], 5'h0});
      apb(1'h1, 8'h10, 32'h20);
    end
    $display("edges done");
  endtask : t_edges
  task automatic t_mask;
    apb(1'h1, 8'h0c, 32'h0);
    apb(1'h1, 8'h08, 32'h60);
    apb(1'h1, 8'h00, 32'h40);
    drv(7'h05, 1'h1);
    drv(7'h06, 1'h1);
    chk(irq, 32'h40);
    apb(1'h1, 8'h10, 32'h000fffff);
    $display("mask done");
  endtask : t_mask
  task automatic t_event;
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h1, 8'h04, 32'h04);
    apb(1'h1, 8'h08, 32'h04);
    ev_cnt = 0;
    drv(7'h02, 1'h1);
    chk(ev_cnt, 32'h1);
    chk(irq, 32'h0);
    $display("event done");
  endtask : t_event
  task automatic t_sel;
    apb(1'h1, 8'h1c, 32'h03020146);
    apb(1'h1, 8'h00, 32'h01);
    apb(1'h1, 8'h08, 32'h01);
    drv(7'h00, 1'h1);
    chk(irq, 32'h0);
    drv(7'h46, 1'h1);
    chk(irq, 32'h1);
    apb(1'h1, 8'h10, 32'h01);
    $display("select done");
  endtask : t_sel
  task automatic t_src;
    apb(1'h1, 8'h00, 32'h70000);
    apb(1'h1, 8'h08, 32'h70000);
    apb(1'h1, 8'h0c, 32'h10000);
    drv(7'h50, 1'h1);
    drv(7'h50, 1'h0);
    chk(irq, 32'h0);
    apb(1'h1, 8'h14, 32'h1);
    chk(mon_en, 32'h1);
    drv(7'h50, 1'h1);
    chk(irq, 32'h10000);
    apb(1'h1, 8'h10, 32'h10000);
    drv(7'h50, 1'h0);
    drv(7'h51, 1'h1);
    drv(7'h52, 1'h1);
    chk(irq, 32'h70000);
    rdc(8'h18, 32'h00060065, 1'h0);
    $display("sources done");
  endtask : t_src
  task automatic wrap_up;
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  // Main sequence, then the watchdog
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_edges();
    t_mask();
    t_event();
    t_sel();
    t_src();
    wrap_up();
  end
  initial
  begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule : test_eec_top
